/* File: verilog/bfm_monitor.sv */
// line and path bit error rate degrade/fail monitor with ring identifier check
//
// How it works
// - The degrade rate threshold is settable from one in ten to the ninth to one in ten to the fifth.
// - The fail rate threshold is settable from one in ten to the fifth to one in ten to the third.
// - Degrade is raised when the measured error rate exceeds the degrade threshold.
// - Fail is raised when the measured error rate exceeds the fail threshold.
// - A raised condition clears only once the rate falls to a tenth of its raising threshold, or to one error per window where that is higher.
// - Fail always stands at a higher error rate than degrade.
// - Line degrade and fail are measured from the line parity byte errors.
// - Path degrade is measured per STS path from the path parity byte errors.
// - Active line degrade or fail requests a line-level working-to-protect switch.
// - Active path degrade requests a path-level working-to-protect switch for that path.
// - Degrade and fail are reported as non-alarmed conditions.
// - A differing neighbour ring identifier raises a major service-affecting alarm.
// - Active path fail requests a path-level working-to-protect switch for that path.
`timescale 1ns/1ps
`default_nettype none
module bfm_monitor #(
   parameter int NPATH = bfm_pkg::BFM_NPATH,
   parameter int WIN_FRAMES = bfm_pkg::BFM_WIN_FRAMES,
   parameter logic [63:0] LINE_WIN_BITS = bfm_pkg::BFM_LINE_WIN_BITS,
   parameter logic [63:0] PATH_WIN_BITS = bfm_pkg::BFM_PATH_WIN_BITS
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // frame timing and parity errors
   input wire logic frame_i,
   input wire logic [bfm_pkg::BFM_ERR_W-1:0] line_b2_err_i,
   input wire logic [NPATH-1:0][bfm_pkg::BFM_ERR_W-1:0] path_b3_err_i,
   // threshold provisioning
   input wire bfm_pkg::bfm_thr_cfg_t line_thr_i,
   input wire bfm_pkg::bfm_thr_cfg_t path_thr_i,
   // ring identifier
   input wire logic [bfm_pkg::BFM_RING_W-1:0] ring_identifier_i,
   input wire logic peer_ring_valid_i,
   input wire logic [bfm_pkg::BFM_RING_W-1:0] peer_ring_identifier_i,
   // line conditions
   output bfm_pkg::bfm_report_t line_degrade_condition_o,
   output bfm_pkg::bfm_report_t line_fail_condition_o,
   output logic line_switch_req_o,
   // path conditions
   output bfm_pkg::bfm_report_t [NPATH-1:0] path_degrade_condition_o,
   output bfm_pkg::bfm_report_t [NPATH-1:0] path_fail_condition_o,
   output logic [NPATH-1:0] path_switch_req_o,
   // ring alarm
   output bfm_pkg::bfm_report_t ring_mismatch_o,
   // applied exponents after clamping
   output bfm_pkg::bfm_thr_cfg_t line_thr_applied_o,
   output bfm_pkg::bfm_thr_cfg_t path_thr_applied_o
);
   import bfm_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (NPATH < 1) begin : g_chk_npath
      $error("NPATH must be at least one");
   end
   if (WIN_FRAMES < 1 || WIN_FRAMES > 32'h00ff_ffff) begin : g_chk_win
      $error("WIN_FRAMES out of range");
   end

   localparam int WIN_W = 24;
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_FRAMES[WIN_W-1:0] - 24'h000001;

   // ------------------------------------------------------------
   // threshold arithmetic
   // ------------------------------------------------------------
   function automatic logic [63:0] pow10(input logic [3:0] e);
      logic [63:0] p;
      p = 64'h0000_0000_0000_0001;
      for (int k = 0; k < 12; k++) begin
         if (k < int'(e)) begin
            p = p * 64'h0000_0000_0000_000a;
         end
      end
      return p;
   endfunction

   // errors per window at one in ten to the e, never below one
   function automatic logic [BFM_CNT_W-1:0] count_of(input logic [63:0] bits,
                                                     input logic [3:0] e);
      logic [63:0] q;
      q = bits / pow10(e);
      if (q > {32'h0000_0000, {BFM_CNT_W{1'b1}}}) begin
         q = {32'h0000_0000, {BFM_CNT_W{1'b1}}};
      end
      if (q == 64'h0) begin
         q = 64'h0000_0000_0000_0001;
      end
      return q[BFM_CNT_W-1:0];
   endfunction

   function automatic bfm_thr_cfg_t clamp_cfg(input bfm_thr_cfg_t c);
      bfm_thr_cfg_t r;
      r = c;
      if (r.degrade_exp < BFM_DEG_EXP_MIN) r.degrade_exp = BFM_DEG_EXP_MIN;
      if (r.degrade_exp > BFM_DEG_EXP_MAX) r.degrade_exp = BFM_DEG_EXP_MAX;
      if (r.fail_exp < BFM_FAIL_EXP_MIN) r.fail_exp = BFM_FAIL_EXP_MIN;
      if (r.fail_exp > BFM_FAIL_EXP_MAX) r.fail_exp = BFM_FAIL_EXP_MAX;
      if (r.degrade_exp <= r.fail_exp) r.degrade_exp = r.fail_exp + 4'h1;
      return r;
   endfunction

   function automatic bfm_thr_cnt_t counts_of(input logic [63:0] bits,
                                              input bfm_thr_cfg_t c);
      bfm_thr_cnt_t t;
      t.degrade_set = count_of(bits, c.degrade_exp);
      t.degrade_clr = count_of(bits, c.degrade_exp + BFM_HYST_DECADE);
      t.fail_set = count_of(bits, c.fail_exp);
      t.fail_clr = count_of(bits, c.fail_exp + BFM_HYST_DECADE);
      return t;
   endfunction

   // ------------------------------------------------------------
   // provisioning registers and window timing
   // ------------------------------------------------------------
   bfm_thr_cfg_t line_cfg_r, line_cfg_nxt;
   bfm_thr_cfg_t path_cfg_r, path_cfg_nxt;
   bfm_thr_cnt_t line_cnt_r, line_cnt_nxt;
   bfm_thr_cnt_t path_cnt_r, path_cnt_nxt;
   logic [WIN_W-1:0] win_r, win_nxt;
   logic restart_r, restart_nxt;
   logic win_end;

   always_comb begin
      line_cfg_nxt = clamp_cfg(line_thr_i);
      path_cfg_nxt = clamp_cfg(path_thr_i);
      line_cnt_nxt = counts_of(LINE_WIN_BITS, line_cfg_r);
      path_cnt_nxt = counts_of(PATH_WIN_BITS, path_cfg_r);
      // a new threshold restarts the window so no stale count is judged
      restart_nxt = (line_cfg_nxt != line_cfg_r) || (path_cfg_nxt != path_cfg_r);
      win_end = frame_i && (win_r == WIN_LAST) && !restart_r;
      win_nxt = win_r;
      if (restart_r) begin
         win_nxt = '0;
      end else if (frame_i) begin
         win_nxt = win_end ? '0 : win_r + 24'h000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_cfg_r <= '{degrade_exp: BFM_DEG_EXP_RST, fail_exp: BFM_FAIL_EXP_RST};
         path_cfg_r <= '{degrade_exp: BFM_DEG_EXP_RST, fail_exp: BFM_FAIL_EXP_RST};
         line_cnt_r <= '1;
         path_cnt_r <= '1;
         win_r <= '0;
         restart_r <= 1'b1;
      end else if (ce_i) begin
         line_cfg_r <= line_cfg_nxt;
         path_cfg_r <= path_cfg_nxt;
         line_cnt_r <= line_cnt_nxt;
         path_cnt_r <= path_cnt_nxt;
         win_r <= win_nxt;
         restart_r <= restart_nxt;
      end
   end

   // ------------------------------------------------------------
   // detectors: line first, then one per STS path
   // ------------------------------------------------------------
   logic line_deg, line_fail;
   logic [NPATH-1:0] path_deg, path_fail;

   bfm_ber_det #(
      .CNT_W(BFM_CNT_W),
      .ERR_W(BFM_ERR_W)
   ) u_line_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .frame_i(frame_i),
      .win_end_i(win_end),
      .restart_i(restart_r),
      .err_i(line_b2_err_i),
      .thr_i(line_cnt_r),
      .degrade_o(line_deg),
      .fail_o(line_fail)
   );

   for (genvar p = 0; p < NPATH; p++) begin : g_path
      bfm_ber_det #(
         .CNT_W(BFM_CNT_W),
         .ERR_W(BFM_ERR_W)
      ) u_path_det (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .frame_i(frame_i),
         .win_end_i(win_end),
         .restart_i(restart_r),
         .err_i(path_b3_err_i[p]),
         .thr_i(path_cnt_r),
         .degrade_o(path_deg[p]),
         .fail_o(path_fail[p])
      );
   end

   // ------------------------------------------------------------
   // ring identifier comparison
   // ------------------------------------------------------------
   bfm_ring_st_t ring_st_r, ring_st_nxt;
   logic [BFM_RING_W-1:0] peer_id_r, peer_id_nxt;

   always_comb begin
      peer_id_nxt = peer_ring_valid_i ? peer_ring_identifier_i : peer_id_r;
      ring_st_nxt = ring_st_r;
      unique case (ring_st_r)
         BFM_RING_WAIT: begin
            if (peer_ring_valid_i) begin
               ring_st_nxt = (peer_ring_identifier_i != ring_identifier_i) ?
                             BFM_RING_MISMATCH : BFM_RING_MATCH;
            end
         end
         BFM_RING_MATCH, BFM_RING_MISMATCH: begin
            // re-provisioning our own id is judged against the last neighbour id
            // compare against neighbour
            ring_st_nxt = (peer_id_nxt != ring_identifier_i) ?
                          BFM_RING_MISMATCH : BFM_RING_MATCH;
         end
         default: begin
            ring_st_nxt = BFM_RING_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ring_st_r <= BFM_RING_WAIT;
         peer_id_r <= '0;
      end else if (ce_i) begin
         ring_st_r <= ring_st_nxt;
         peer_id_r <= peer_id_nxt;
      end
   end

   // ------------------------------------------------------------
   // reporting and switch requests
   // ------------------------------------------------------------
   logic line_sw_r, line_sw_nxt;
   logic [NPATH-1:0] path_sw_r, path_sw_nxt;
   bfm_report_t ring_rep_r, ring_rep_nxt;

   always_comb begin
      line_sw_nxt = line_deg || line_fail;
      path_sw_nxt = path_deg | path_fail;
      ring_rep_nxt = '{active: (ring_st_r == BFM_RING_MISMATCH),
                       severity: BFM_SEV_MAJOR,
                       service_affecting: 1'b1};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_sw_r <= 1'b0;
         path_sw_r <= '0;
         ring_rep_r <= '{active: 1'b0, severity: BFM_SEV_MAJOR, service_affecting: 1'b1};
      end else if (ce_i) begin
         line_sw_r <= line_sw_nxt;
         path_sw_r <= path_sw_nxt;
         ring_rep_r <= ring_rep_nxt;
      end
   end

   assign line_degrade_condition_o = '{active: line_deg, severity: BFM_SEV_NA,
                                       service_affecting: 1'b0};
   assign line_fail_condition_o = '{active: line_fail, severity: BFM_SEV_NA,
                                    service_affecting: 1'b0};
   for (genvar q = 0; q < NPATH; q++) begin : g_rep
      assign path_degrade_condition_o[q] = '{active: path_deg[q], severity: BFM_SEV_NA,
                                             service_affecting: 1'b0};
      assign path_fail_condition_o[q] = '{active: path_fail[q], severity: BFM_SEV_NA,
                                          service_affecting: 1'b0};
   end

   assign line_switch_req_o = line_sw_r;
   assign path_switch_req_o = path_sw_r;
   assign ring_mismatch_o = ring_rep_r;
   assign line_thr_applied_o = line_cfg_r;
   assign path_thr_applied_o = path_cfg_r;

endmodule // bfm_monitor
`default_nettype wire

/* File: verilog/bfm_pkg.sv */
// shared constants and carrier types of the bit error rate degrade/fail monitor
package bfm_pkg;

   // ------------------------------------------------------------
   // threshold exponents: rate is one error in ten to the exp
   // ------------------------------------------------------------
   localparam logic [3:0] BFM_DEG_EXP_MIN = 4'h5;
   localparam logic [3:0] BFM_DEG_EXP_MAX = 4'h9;
   localparam logic [3:0] BFM_FAIL_EXP_MIN = 4'h3;
   localparam logic [3:0] BFM_FAIL_EXP_MAX = 4'h5;
   localparam logic [3:0] BFM_DEG_EXP_RST = 4'h6;
   localparam logic [3:0] BFM_FAIL_EXP_RST = 4'h3;
   // clearing level is one decade below the raising level
   localparam logic [3:0] BFM_HYST_DECADE = 4'h1;

   // ------------------------------------------------------------
   // observation window and counter widths
   // ------------------------------------------------------------
   localparam int BFM_CNT_W = 32;
   localparam int BFM_ERR_W = 8;
   localparam int BFM_RING_W = 16;
   localparam int BFM_WIN_FRAMES = 8000;
   localparam logic [63:0] BFM_LINE_WIN_BITS = 64'h0000_0000_3b9a_ca00;
   localparam logic [63:0] BFM_PATH_WIN_BITS = 64'h0000_0000_3b9a_ca00;
   localparam int BFM_NPATH = 3;

   // ------------------------------------------------------------
   // reporting classes
   // ------------------------------------------------------------
   localparam logic [1:0] BFM_SEV_NA = 2'h0;
   localparam logic [1:0] BFM_SEV_MINOR = 2'h1;
   localparam logic [1:0] BFM_SEV_MAJOR = 2'h2;
   localparam logic [1:0] BFM_SEV_CRIT = 2'h3;

   typedef struct packed {
      logic active;
      logic [1:0] severity;
      logic service_affecting;
   } bfm_report_t;

   typedef struct packed {
      logic [3:0] degrade_exp;
      logic [3:0] fail_exp;
   } bfm_thr_cfg_t;

   typedef struct packed {
      logic [BFM_CNT_W-1:0] degrade_set;
      logic [BFM_CNT_W-1:0] degrade_clr;
      logic [BFM_CNT_W-1:0] fail_set;
      logic [BFM_CNT_W-1:0] fail_clr;
   } bfm_thr_cnt_t;

   typedef enum logic [2:0] {
      BFM_RING_WAIT = 3'b001,
      BFM_RING_MATCH = 3'b010,
      BFM_RING_MISMATCH = 3'b100
   } bfm_ring_st_t;

endpackage : bfm_pkg

/* File: verilog/bfm_ber_det.sv */
// one error counter with degrade and fail hysteresis detection
`timescale 1ns/1ps
`default_nettype none
module bfm_ber_det #(
   parameter int CNT_W = bfm_pkg::BFM_CNT_W,
   parameter int ERR_W = bfm_pkg::BFM_ERR_W
) (
   // clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // window timing
   input wire logic frame_i,
   input wire logic win_end_i,
   input wire logic restart_i,
   // parity violations this frame
   input wire logic [ERR_W-1:0] err_i,
   // count thresholds
   input wire bfm_pkg::bfm_thr_cnt_t thr_i,
   // detected conditions
   output logic degrade_o,
   output logic fail_o
);
   import bfm_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ERR_W < 1 || ERR_W > CNT_W) begin : g_chk_w
      $error("ERR_W must lie between one and CNT_W");
   end

   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic deg_r, deg_nxt;
   logic fail_r, fail_nxt;
   logic [CNT_W:0] sum;
   logic [CNT_W-1:0] total;

   // ------------------------------------------------------------
   // counting and hysteresis
   // ------------------------------------------------------------
   always_comb begin
      sum = {1'b0, cnt_r} + {{(CNT_W + 1 - ERR_W){1'b0}}, err_i};
      // saturate so a burst never wraps to a low count
      total = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
      cnt_nxt = cnt_r;
      deg_nxt = deg_r;
      fail_nxt = fail_r;
      if (restart_i) begin
         cnt_nxt = '0;
      end else if (frame_i) begin
         cnt_nxt = win_end_i ? '0 : total;
         if (win_end_i) begin
            if (!deg_r && total > thr_i.degrade_set) begin
               deg_nxt = 1'b1;
            end else if (deg_r && total <= thr_i.degrade_clr) begin
               deg_nxt = 1'b0;
            end
            if (!fail_r && total > thr_i.fail_set) begin
               fail_nxt = 1'b1;
            end else if (fail_r && total <= thr_i.fail_clr) begin
               fail_nxt = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         deg_r <= 1'b0;
         fail_r <= 1'b0;
      end else if (ce_i) begin
         cnt_r <= cnt_nxt;
         deg_r <= deg_nxt;
         fail_r <= fail_nxt;
      end
   end

   assign degrade_o = deg_r;
   assign fail_o = fail_r;

endmodule // bfm_ber_det
`default_nettype wire

/* File: test/bfm_monitor_assertions.sv */
// concurrent checks on the ports of the degrade/fail monitor
`timescale 1ns/1ps
`default_nettype none
module bfm_monitor_assertions #(
   parameter int NPATH = 3
) (
   // clock, reset, inputs
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic frame_i,
   input wire logic [bfm_pkg::BFM_RING_W-1:0] ring_identifier_i,
   input wire logic peer_ring_valid_i,
   input wire logic [bfm_pkg::BFM_RING_W-1:0] peer_ring_identifier_i,
   // outputs watched
   input wire bfm_pkg::bfm_report_t line_degrade_condition_o,
   input wire bfm_pkg::bfm_report_t line_fail_condition_o,
   input wire logic line_switch_req_o,
   input wire bfm_pkg::bfm_report_t [NPATH-1:0] path_degrade_condition_o,
   input wire bfm_pkg::bfm_report_t [NPATH-1:0] path_fail_condition_o,
   input wire logic [NPATH-1:0] path_switch_req_o,
   input wire bfm_pkg::bfm_report_t ring_mismatch_o,
   input wire bfm_pkg::bfm_thr_cfg_t line_thr_applied_o
);
   import bfm_pkg::*;
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic [NPATH-1:0] path_any;
   logic path_cls_ok;
   logic seen_r;
   logic seen_nxt;
   always_comb begin
      path_cls_ok = 1'b1;
      for (int p = 0; p < NPATH; p++) begin
         path_any[p] = path_degrade_condition_o[p].active | path_fail_condition_o[p].active;
         if (path_degrade_condition_o[p].severity != BFM_SEV_NA
               || path_degrade_condition_o[p].service_affecting
               || path_fail_condition_o[p].severity != BFM_SEV_NA
               || path_fail_condition_o[p].service_affecting) begin
            path_cls_ok = 1'b0;
         end
      end
   end
   always_comb seen_nxt = seen_r | (ce_i & peer_ring_valid_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_r <= 1'b0;
      end else begin
         seen_r <= seen_nxt;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_line_switch_req: assert property (
      $rose(line_degrade_condition_o.active) && ce_i |=> line_switch_req_o)
      else $error("line switch request missing after degrade");
   a_path_switch_req: assert property (
      ce_i |=> path_switch_req_o == $past(path_any))
      else $error("path switch request does not follow path conditions");
   a_fail_above_degrade: assert property (
      line_fail_condition_o.active |-> line_degrade_condition_o.active)
      else $error("line fail active without line degrade");
   a_window_end_only: assert property (
      !(frame_i && ce_i) |=> $stable(line_degrade_condition_o.active)
         && $stable(line_fail_condition_o.active))
      else $error("line condition changed without a frame");
   a_not_alarmed: assert property (
      line_degrade_condition_o.severity == BFM_SEV_NA && !line_degrade_condition_o.service_affecting
         && line_fail_condition_o.severity == BFM_SEV_NA && !line_fail_condition_o.service_affecting)
      else $error("line condition reported with a severity");
   a_ring_class: assert property (
      ring_mismatch_o.severity == BFM_SEV_MAJOR && ring_mismatch_o.service_affecting)
      else $error("ring alarm not major service affecting");
   a_ring_quiet: assert property (
      !seen_r |-> !ring_mismatch_o.active)
      else $error("ring alarm before any neighbour report");
   a_ring_latency: assert property (
      ce_i && peer_ring_valid_i && peer_ring_identifier_i != ring_identifier_i
         ##1 ce_i && $stable(ring_identifier_i) |=> ring_mismatch_o.active)
      else $error("ring alarm late after differing neighbour");
   a_exp_range: assert property (
      line_thr_applied_o.degrade_exp inside {[BFM_DEG_EXP_MIN:BFM_DEG_EXP_MAX]}
         && line_thr_applied_o.fail_exp inside {[BFM_FAIL_EXP_MIN:BFM_FAIL_EXP_MAX]}
         && line_thr_applied_o.degrade_exp > line_thr_applied_o.fail_exp)
      else $error("applied exponents out of range");
   a_path_not_alarmed: assert property (
      path_cls_ok)
      else $error("path condition reported with a severity");
endmodule // bfm_monitor_assertions
`default_nettype wire

/* File: test/bfm_upstream_model.sv */
// upstream node model: frame strobes carrying parity violation counts
`timescale 1ns/1ps
`default_nettype none
module bfm_upstream_model #(
   parameter int NPATH = 3,
   parameter int NFRAMES = 4,
   parameter int GAP = 3,
   parameter int HIT = 1
) (
   // bench control
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [bfm_pkg::BFM_ERR_W-1:0] err_i,
   output logic done_o,
   // line side
   output logic frame_o,
   output logic [bfm_pkg::BFM_ERR_W-1:0] line_b2_err_o,
   output logic [NPATH-1:0][bfm_pkg::BFM_ERR_W-1:0] path_b3_err_o
);
   // one window of frames per start; only path HIT sees errors
   initial begin
      done_o = 1'b0;
      frame_o = 1'b0;
      line_b2_err_o = '0;
      path_b3_err_o = '0;
      forever begin
         // start moves on the falling edge, so it is looked at on the rising one
         @(posedge clk_i);
         if (start_i === 1'b1) begin
            for (int f = 0; f < NFRAMES; f++) begin
               @(negedge clk_i);
               frame_o = 1'b1;
               line_b2_err_o = err_i;
               path_b3_err_o = '0;
               path_b3_err_o[HIT] = err_i;
               @(negedge clk_i);
               // counts mean nothing off the strobe, so they toggle
               frame_o = 1'b0;
               line_b2_err_o = ~line_b2_err_o;
               path_b3_err_o = ~path_b3_err_o;
               repeat (GAP) @(negedge clk_i);
            end
            done_o = 1'b1;
            while (start_i === 1'b1) @(posedge clk_i);
            done_o = 1'b0;
         end
      end
   end
endmodule // bfm_upstream_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the degrade/fail monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
   import bfm_pkg::*;
   localparam int NPATH = 3;
   // small window: 1e5 bits, exponent 5 gives a raising count of 1
   localparam logic [63:0] WBITS = 64'h0000_0000_0001_86a0;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic start = 1'b0;
   logic done;
   logic [7:0] err = 8'h00;
   logic frame;
   logic [7:0] line_err;
   logic [NPATH-1:0][7:0] path_err;
   bfm_thr_cfg_t line_thr = 8'h53;
   bfm_thr_cfg_t path_thr = 8'h53;
   logic [15:0] own_id = 16'h1234;
   logic [15:0] peer_id = 16'h0000;
   logic peer_valid = 1'b0;
   bfm_report_t line_deg, line_fail, ring;
   bfm_report_t [NPATH-1:0] path_deg, path_fail;
   logic line_sw;
   logic [NPATH-1:0] path_sw;
   bfm_thr_cfg_t line_app, path_app;
   int checked = 0;
   int miscompares = 0;
   always #10 clk_i = ~clk_i;
   bfm_upstream_model #(.NPATH(NPATH), .NFRAMES(4)) u_far (.clk_i(clk_i), .start_i(start),
      .err_i(err), .done_o(done), .frame_o(frame), .line_b2_err_o(line_err),
      .path_b3_err_o(path_err));
   bfm_monitor #(.NPATH(NPATH), .WIN_FRAMES(4), .LINE_WIN_BITS(WBITS), .PATH_WIN_BITS(WBITS)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .frame_i(frame), .line_b2_err_i(line_err),
      .path_b3_err_i(path_err), .line_thr_i(line_thr), .path_thr_i(path_thr),
      .ring_identifier_i(own_id), .peer_ring_valid_i(peer_valid),
      .peer_ring_identifier_i(peer_id), .line_degrade_condition_o(line_deg),
      .line_fail_condition_o(line_fail), .line_switch_req_o(line_sw),
      .path_degrade_condition_o(path_deg), .path_fail_condition_o(path_fail),
      .path_switch_req_o(path_sw), .ring_mismatch_o(ring), .line_thr_applied_o(line_app),
      .path_thr_applied_o(path_app));
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic results();
      if (checked > 0 && miscompares == 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // four frames of e errors each; path 1 carries the same counts
   task automatic run_window(input logic [7:0] e, input logic d, input logic f);
      int i;
      err = e;
      start = 1'b1;
      for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk_i);
      if (done !== 1'b1) begin
         miscompares++;
         results();
      end
      start = 1'b0;
      @(negedge clk_i);
      `CHK("line_degrade", d, line_deg.active)
      `CHK("line_fail", f, line_fail.active)
      `CHK("line_switch", d | f, line_sw)
      for (int p = 0; p < NPATH; p++) begin
         `CHK("path_degrade", (p == 1) & d, path_deg[p].active)
         `CHK("path_fail", (p == 1) & f, path_fail[p].active)
         `CHK("path_switch", (p == 1) & (d | f), path_sw[p])
      end
   endtask
   task automatic test_reset();
      `CHK("line_report", 4'h0, line_deg)
      `CHK("ring_report", 4'h5, ring)
      `CHK("applied_reset", 8'h63, line_app)
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic test_raise();
      run_window(8'h01, 1'b1, 1'b0);
      run_window(8'h1a, 1'b1, 1'b1);
   endtask
   task automatic test_clamp();
      logic [7:0] cin [4] = '{8'h33, 8'h55, 8'hf0, 8'h47};
      logic [7:0] cexp [4] = '{8'h53, 8'h65, 8'h93, 8'h65};
      for (int k = 0; k < 4; k++) begin
         line_thr = cin[k];
         repeat (2) @(negedge clk_i);
         `CHK("line_applied", cexp[k], line_app)
      end
      `CHK("degrade_kept", 1'b1, line_deg.active)
      `CHK("fail_kept", 1'b1, line_fail.active)
      `CHK("path_applied", 8'h53, path_app)
      line_thr = 8'h53;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic test_hysteresis();
      run_window(8'h05, 1'b1, 1'b1);
      run_window(8'h02, 1'b1, 1'b0);
      run_window(8'h00, 1'b0, 1'b0);
   endtask
   task automatic test_ring();
      ce_i = 1'b0;
      peer_id = 16'h4321;
      peer_valid = 1'b1;
      @(negedge clk_i);
      ce_i = 1'b1;
      peer_valid = 1'b0;
      repeat (3) @(negedge clk_i);
      `CHK("ring_frozen", 1'b0, ring.active)
      peer_valid = 1'b1;
      @(negedge clk_i);
      peer_valid = 1'b0;
      `CHK("ring_early", 1'b0, ring.active)
      @(negedge clk_i);
      `CHK("ring_raised", 4'hd, ring)
      // neighbour and own identifiers made identical
      own_id = 16'h4321;
      repeat (2) @(negedge clk_i);
      `CHK("ring_cleared", 1'b0, ring.active)
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      test_reset();
      test_raise();
      test_clamp();
      test_hysteresis();
      test_ring();
      results();
   end
endmodule // testbench
bind bfm_monitor bfm_monitor_assertions #(.NPATH(NPATH)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .frame_i(frame_i), .ring_identifier_i(ring_identifier_i),
   .peer_ring_valid_i(peer_ring_valid_i), .peer_ring_identifier_i(peer_ring_identifier_i),
   .line_degrade_condition_o(line_degrade_condition_o),
   .line_fail_condition_o(line_fail_condition_o), .line_switch_req_o(line_switch_req_o),
   .path_degrade_condition_o(path_degrade_condition_o),
   .path_fail_condition_o(path_fail_condition_o), .path_switch_req_o(path_switch_req_o),
   .ring_mismatch_o(ring_mismatch_o), .line_thr_applied_o(line_thr_applied_o));
`default_nettype wire
